// ==== tb/keypad_matrix_model.sv ====
// switch matrix: a row follows the driven columns of its pressed keys
// assumes pull-downs on the rows, so undriven rows read low
`timescale 1ns/100ps
module keypad_matrix_model
(
  // columns from the scanner
  input  wire logic [5:0]  col_drive,
  input  wire logic [5:0]  col_oe,
  // key k sits at column k/5, row k%5
  input  wire logic [29:0] pressed,
  // rows to the scanner
  output logic      [4:0]  rows
);
  always_comb
  begin
    rows = 5'h00;
    for (int c = 0; c < 6; c++)
      if (col_oe[c] && col_drive[c])
        rows = rows | pressed[c*5 +: 5];
  end
endmodule

// ==== tb/keypad_scan_interrupt_tb_top.sv ====
// self-checking bench for the keypad scanner and its register slave
// assumes the matrix model answers on the row lines
`timescale 1ns/100ps
module keypad_scan_interrupt_tb_top;
  logic                 clk;
  logic                 rst_n;
  keypad_pkg::bus_req_t req;
  logic [31:0]          rdata;
  logic                 wait_req;
  logic [4:0]           rows;
  logic [5:0]           cols;
  logic [5:0]           cols_oe;
  logic                 key_n;
  logic                 irq;
  logic [29:0]          pressed;
  logic [31:0]          rd;
  int                   n_fail = 0;
  int                   check_count = 0;
  int                   cyc = 0;

  keypad_scan_interrupt #(.DEBOUNCE_CYCLES(4)) dut
  (
    .CORE_CLK           (clk),
    .RESETN             (rst_n),
    .AVS_ADDRESS        (req.address),
    .AVS_READ           (req.read),
    .AVS_WRITE          (req.write),
    .AVS_WRITEDATA      (req.writedata),
    .AVS_READDATA       (rdata),
    .AVS_WAITREQUEST    (wait_req),
    .ROW_SENSE_LINES    (rows),
    .COLUMN_DRIVE_LINES (cols),
    .COLUMN_DRIVE_OE    (cols_oe),
    .KEY_EVENT_OUT_N    (key_n),
    .IRQ                (irq)
  );
  keypad_matrix_model matrix
  (
    .col_drive (cols),
    .col_oe    (cols_oe),
    .pressed   (pressed),
    .rows      (rows)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one access; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    req <= '{address: a, read: !wr, write: wr, writedata: wd};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 50);
    rd = rdata;
    req <= '{address: a, read: 1'b0, write: 1'b0, writedata: wd};
    @(posedge clk);
    chk(32'(n < 50), 32'h1, "bus answer");
  endtask

  task automatic wait_key(input logic lvl);
    int n;
    n = 0;
    while (key_n !== lvl && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(key_n), 32'(lvl), "event level");
  endtask

  task automatic regs_after_reset;
    chk({24'h0, irq, cols_oe, key_n}, 32'h1, "reset outputs");
    bus(1'b0, keypad_pkg::OFS_KEY_MASK_LO, 32'h0);
    chk(rd, 32'(keypad_pkg::KEY_MASK_RST), "key mask reset");
    bus(1'b0, keypad_pkg::OFS_COL_MASK, 32'h0);
    chk(rd, 32'(keypad_pkg::COL_MASK_RST), "column mask reset");
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, keypad_pkg::UNMAPPED_DATA, "unmapped read");
    bus(1'b1, keypad_pkg::OFS_STATUS, 32'hffff_ffff);
    bus(1'b0, keypad_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0, "status read-only");
  endtask

  // with detection off a held key must leave the event line alone
  task automatic detect_off;
    pressed <= 30'h0000_0080;
    repeat (20) @(posedge clk);
    chk({26'h0, cols_oe}, 32'h0, "columns released");
    chk(32'(key_n), 32'h1, "no event when off");
    pressed <= 30'h0;
  endtask

  // press, let the scan finish, then read what software should see
  task automatic scan_keys(input logic [29:0] p, input logic [29:0] km, input logic [5:0] cm, input logic [1:0] ie);
    logic [29:0] v;
    v = p & ~km;
    for (int c = 0; c < 6; c++)
      if (cm[c])
        v[c*5 +: 5] = 5'h00;
    bus(1'b1, keypad_pkg::OFS_KEY_MASK_LO, {17'h0, km[14:0]});
    bus(1'b1, keypad_pkg::OFS_KEY_MASK_HI, {17'h0, km[29:15]});
    bus(1'b1, keypad_pkg::OFS_COL_MASK, {26'h0, cm});
    bus(1'b0, keypad_pkg::OFS_KEY_MASK_HI, 32'h0);
    chk(rd, {17'h0, km[29:15]}, "key mask readback");
    bus(1'b1, keypad_pkg::OFS_IRQ_ENABLE, {30'h0, ie});
    bus(1'b1, keypad_pkg::OFS_CONTROL, 32'h1);
    @(posedge clk);
    chk({26'h0, cols_oe & cols}, 32'h3f, "idle columns");
    pressed <= p;
    wait_key(1'b0);
    wait_key(1'b1);
    repeat (20) @(posedge clk);
    chk(32'(key_n), 32'h1, "event before read");
    chk({26'h0, cols_oe}, 32'h0, "rescan before read");
    chk(32'(irq), 32'(|ie), "irq after scan");
    bus(1'b0, keypad_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h2, "result pending");
    pressed <= 30'h0;
    bus(1'b0, keypad_pkg::OFS_RESULT_LO, 32'h0);
    chk(rd, {17'h0, v[14:0]}, "first result");
    bus(1'b0, keypad_pkg::OFS_RESULT_HI, 32'h0);
    chk(rd, {17'h0, v[29:15]}, "second result");
    bus(1'b1, keypad_pkg::OFS_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always #4 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    pressed = 30'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    regs_after_reset();
    detect_off();
    scan_keys(30'h2000_0011, 30'h0, 6'h00, 2'h3);
    scan_keys(30'h2000_8011, 30'h0010_0010, 6'h20, 2'h0);
    scan_keys(30'h0000_0011, 30'h0, 6'h3f, 2'h1);
    stop_test();
  end
endmodule

// ==== tb/keypad_scan_monitor.sv ====
// port checker for the keypad scanner
// assumes it is bound onto keypad_scan_interrupt
`timescale 1ns/100ps
module keypad_scan_monitor
#(
  parameter int DEBOUNCE_CYCLES = keypad_pkg::DEBOUNCE_CYC
)
(
  // clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RESETN,
  // bus
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic       AVS_READ,
  input wire logic       AVS_WAITREQUEST,
  // matrix and event
  input wire logic [4:0] ROW_SENSE_LINES,
  input wire logic [5:0] COLUMN_DRIVE_LINES,
  input wire logic [5:0] COLUMN_DRIVE_OE,
  input wire logic       KEY_EVENT_OUT_N
);
  logic hold_r;
  int   wait_r;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // set from a finished scan until software reads a result
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      hold_r <= 1'b0;
    else if ($rose(KEY_EVENT_OUT_N))
      hold_r <= 1'b1;
    else if (AVS_READ && !AVS_WAITREQUEST &&
             (AVS_ADDRESS == keypad_pkg::OFS_RESULT_LO || AVS_ADDRESS == keypad_pkg::OFS_RESULT_HI))
      hold_r <= 1'b0;
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      wait_r <= 0;
    else if (!KEY_EVENT_OUT_N && COLUMN_DRIVE_OE == 6'h3f)
      wait_r <= wait_r + 1;
    else
      wait_r <= 0;
  cols_high_a: assert property ((COLUMN_DRIVE_OE & ~COLUMN_DRIVE_LINES) == 6'h00)
    else $error("driven column not high");
  press_low_a: assert property (KEY_EVENT_OUT_N && COLUMN_DRIVE_OE == 6'h3f && ROW_SENSE_LINES != 5'h00
    |=> !KEY_EVENT_OUT_N) else $error("press not flagged");
  one_col_a: assert property (COLUMN_DRIVE_OE != 6'h3f |-> $onehot0(COLUMN_DRIVE_OE))
    else $error("several columns driven");
  col_hold_a: assert property ($changed(COLUMN_DRIVE_OE) && $onehot(COLUMN_DRIVE_OE)
    |=> $stable(COLUMN_DRIVE_OE) [*8]) else $error("column driven too briefly");
  // columns are separated by one released cycle, so compare with the column two cycles back
  col_order_a: assert property ($onehot(COLUMN_DRIVE_OE) && $past(COLUMN_DRIVE_OE) == 6'h00
    && $onehot($past(COLUMN_DRIVE_OE, 2)) |-> COLUMN_DRIVE_OE > $past(COLUMN_DRIVE_OE, 2))
    else $error("column order");
  debounce_wait_a: assert property ($onehot(COLUMN_DRIVE_OE) && $past(COLUMN_DRIVE_OE) == 6'h3f
    |-> wait_r >= DEBOUNCE_CYCLES) else $error("scan before debounce end");
  rearm_hold_a: assert property (hold_r |-> KEY_EVENT_OUT_N)
    else $error("event before result read");
  no_rescan_a: assert property (hold_r && $past(hold_r) |-> COLUMN_DRIVE_OE == 6'h00)
    else $error("columns driven before result read");
endmodule
bind keypad_scan_interrupt keypad_scan_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) mon
(
  .CORE_CLK           (CORE_CLK),
  .RESETN             (RESETN),
  .AVS_ADDRESS        (AVS_ADDRESS),
  .AVS_READ           (AVS_READ),
  .AVS_WAITREQUEST    (AVS_WAITREQUEST),
  .ROW_SENSE_LINES    (ROW_SENSE_LINES),
  .COLUMN_DRIVE_LINES (COLUMN_DRIVE_LINES),
  .COLUMN_DRIVE_OE    (COLUMN_DRIVE_OE),
  .KEY_EVENT_OUT_N    (KEY_EVENT_OUT_N)
);

// ==== verilog/keypad_pkg.sv ====
// keypad scanner package: register offsets, field layouts, reset values, timing counts
// assumes a 125 MHz core clock and a 32-bit avalon-mm register slave
package keypad_pkg;

  localparam int          CLK_MHZ         = 125;
  localparam int          DEBOUNCE_US     = 10;
  localparam int          DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
  localparam int          SETTLE_NS       = 64;
  localparam int          SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  localparam int          ROWS            = 5;
  localparam int          COLS            = 6;
  localparam int          KEYS            = 30;

  localparam logic [3:0]  OFS_RESULT_LO   = 4'h0;
  localparam logic [3:0]  OFS_RESULT_HI   = 4'h1;
  localparam logic [3:0]  OFS_KEY_MASK_LO = 4'h2;
  localparam logic [3:0]  OFS_KEY_MASK_HI = 4'h3;
  localparam logic [3:0]  OFS_COL_MASK    = 4'h4;
  localparam logic [3:0]  OFS_CONTROL     = 4'h5;
  localparam logic [3:0]  OFS_STATUS      = 4'h6;
  localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h7;
  localparam logic [3:0]  OFS_IRQ_ENABLE  = 4'h8;
  localparam logic [3:0]  OFS_IRQ_CLEAR   = 4'h9;

  localparam int          CTRL_DETECT_EN  = 0;
  localparam int          STAT_BUSY       = 0;
  localparam int          STAT_PENDING    = 1;
  localparam int          IRQ_SCAN_DONE   = 0;
  localparam int          IRQ_PRESS       = 1;
  localparam int          IRQ_BITS        = 2;

  localparam logic [14:0] KEY_MASK_RST    = 15'h0000;
  localparam logic [5:0]  COL_MASK_RST    = 6'h00;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [5:0] drive;
    logic [5:0] enable;
  } column_pins_t;

endpackage

// ==== verilog/keypad_scan_interrupt.sv ====
// keypad matrix scanner with key interrupt, 5 rows by 6 columns, avalon-mm register slave
// assumes row inputs are synchronous to CORE_CLK and the board pulls rows low
//
// Contract
// RQ1 - five row inputs, six column outputs, up to thirty keys, smaller matrices allowed
// RQ2 - per-key masks in two registers and a column mask make unused keys ignored
// RQ3 - with detection enabled all six columns drive high, rows rely on pull-downs
// RQ4 - a row going high in detection mode drives the key event output low
// RQ5 - the key event output returns high when the triggered scan completes
// RQ6 - after a scan, no new low until the host reads either result register
// RQ7 - scan drives one column at a time from the first, others released, samples rows
// RQ8 - column sequence runs at end of debounce, results loaded only afterwards
// RQ9 - host checks completion before reading; no new scan until results are read
// RQ10 - several keys pressed in one column are all recorded in that column
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module keypad_scan_interrupt
#(
  parameter int DEBOUNCE_CYCLES = keypad_pkg::DEBOUNCE_CYC
)
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // keypad matrix
  input  wire logic [4:0]  ROW_SENSE_LINES,
  output logic      [5:0]  COLUMN_DRIVE_LINES,
  output logic      [5:0]  COLUMN_DRIVE_OE,
  // events
  output logic             KEY_EVENT_OUT_N,
  output logic             IRQ
);

  typedef enum logic [2:0] {IDLE, DEBOUNCE, DRIVE, SETTLE, NEXT, DONE} scan_state_t;

  scan_state_t             state_r;
  keypad_pkg::bus_req_t    req;
  keypad_pkg::column_pins_t pins_nxt;
  logic [14:0]             key_mask_low_r;
  logic [14:0]             key_mask_high_r;
  logic [5:0]              column_mask_r;
  logic                    detect_en_r;
  logic [29:0]             capture_r;
  logic [29:0]             result_r;
  logic                    pending_r;
  logic [2:0]              col_r;
  logic [15:0]             count_r;
  logic                    ack_r;
  logic [keypad_pkg::IRQ_BITS-1:0] irq_status_r;
  logic [keypad_pkg::IRQ_BITS-1:0] irq_enable_r;
  logic                    bus_write;
  logic                    bus_read;
  logic                    result_read;
  logic                    press_seen;
  logic                    scan_done;
  logic [keypad_pkg::IRQ_BITS-1:0] irq_clear;

  // key index k maps to column k/5 and row k%5, so one column holds five consecutive keys
  function automatic logic [29:0] key_enable(input logic [14:0] lo, input logic [14:0] hi,
                                             input logic [5:0] cm);
    logic [29:0] e;
    e = {hi, lo};
    for (int c = 0; c < keypad_pkg::COLS; c++)
    begin
      if (cm[c])
      begin
        e[c*5 +: 5] = 5'h1f;
      end
    end
    return ~e;
  endfunction

  // next unmasked column after c, or COLS when none remains; c of 7 means before the first column
  function automatic logic [2:0] next_column(input logic [2:0] c, input logic [5:0] cm);
    logic [2:0] n;
    n = 3'(keypad_pkg::COLS);
    for (int i = keypad_pkg::COLS - 1; i >= 0; i--)
    begin
      if ((c == 3'h7 || i > int'(c)) && !cm[i])
      begin
        n = 3'(i);
      end
    end
    return n;
  endfunction

  always_comb
  begin
    req.address   = AVS_ADDRESS;
    req.read      = AVS_READ;
    req.write     = AVS_WRITE;
    req.writedata = AVS_WRITEDATA;
  end

  // every access takes two cycles: the request sits one cycle with waitrequest high
  assign bus_write   = req.write && ack_r;
  assign bus_read    = req.read && ack_r;
  assign result_read = bus_read && (req.address == keypad_pkg::OFS_RESULT_LO ||
                                    req.address == keypad_pkg::OFS_RESULT_HI);  // [RQ6]
  assign press_seen  = (state_r == IDLE) && detect_en_r && !pending_r &&
                       (|ROW_SENSE_LINES);                                     // [RQ4] [RQ9]
  assign scan_done   = (state_r == DONE);
  assign irq_clear   = (bus_write && req.address == keypad_pkg::OFS_IRQ_CLEAR) ?
                       req.writedata[keypad_pkg::IRQ_BITS-1:0] : '0;

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= (req.read || req.write) && !ack_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end
    else
    begin
      AVS_WAITREQUEST <= !((req.read || req.write) && !ack_r);
      AVS_READDATA    <= keypad_pkg::UNMAPPED_DATA;
      if (req.read && !ack_r)
      begin
        unique case (req.address)
          keypad_pkg::OFS_RESULT_LO:   AVS_READDATA <= {17'h00000, result_r[14:0]};
          keypad_pkg::OFS_RESULT_HI:   AVS_READDATA <= {17'h00000, result_r[29:15]};
          keypad_pkg::OFS_KEY_MASK_LO: AVS_READDATA <= {17'h00000, key_mask_low_r};
          keypad_pkg::OFS_KEY_MASK_HI: AVS_READDATA <= {17'h00000, key_mask_high_r};
          keypad_pkg::OFS_COL_MASK:    AVS_READDATA <= {26'h0000000, column_mask_r};
          keypad_pkg::OFS_CONTROL:     AVS_READDATA <= {31'h00000000, detect_en_r};
          keypad_pkg::OFS_STATUS:      AVS_READDATA <= {30'h00000000, pending_r, state_r != IDLE};
          keypad_pkg::OFS_IRQ_STATUS:  AVS_READDATA <= {30'h00000000, irq_status_r};
          keypad_pkg::OFS_IRQ_ENABLE:  AVS_READDATA <= {30'h00000000, irq_enable_r};
          default:                     AVS_READDATA <= keypad_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      key_mask_low_r  <= keypad_pkg::KEY_MASK_RST;
      key_mask_high_r <= keypad_pkg::KEY_MASK_RST;
      column_mask_r   <= keypad_pkg::COL_MASK_RST;
      detect_en_r     <= 1'b0;
      irq_enable_r    <= '0;
    end
    else if (bus_write)
    begin
      unique case (req.address)
        keypad_pkg::OFS_KEY_MASK_LO: key_mask_low_r  <= req.writedata[14:0];  // [RQ2]
        keypad_pkg::OFS_KEY_MASK_HI: key_mask_high_r <= req.writedata[14:0];  // [RQ2]
        keypad_pkg::OFS_COL_MASK:    column_mask_r   <= req.writedata[5:0];   // [RQ2]
        keypad_pkg::OFS_CONTROL:     detect_en_r     <= req.writedata[keypad_pkg::CTRL_DETECT_EN];
        keypad_pkg::OFS_IRQ_ENABLE:  irq_enable_r    <= req.writedata[keypad_pkg::IRQ_BITS-1:0];
        default:                     ;
      endcase
    end
  end

  // scan sequencer
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_r   <= IDLE;
      col_r     <= 3'h0;
      count_r   <= 16'h0000;
      capture_r <= 30'h00000000;
    end
    else
    begin
      unique case (state_r)
        IDLE:
        begin
          count_r <= 16'h0000;
          if (press_seen)
          begin
            state_r <= DEBOUNCE;
          end
        end
        DEBOUNCE:
        begin
          count_r <= count_r + 16'h0001;
          if (count_r >= 16'(DEBOUNCE_CYCLES - 1))
          begin
            capture_r <= 30'h00000000;
            col_r     <= next_column(3'h7, column_mask_r);                    // [RQ8]
            state_r   <= (next_column(3'h7, column_mask_r) == 3'(keypad_pkg::COLS)) ? DONE : DRIVE;
          end
        end
        DRIVE:
        begin
          count_r <= 16'h0000;
          state_r <= SETTLE;
        end
        SETTLE:
        begin
          count_r <= count_r + 16'h0001;
          if (count_r >= 16'(keypad_pkg::SETTLE_CYC - 1))
          begin
            capture_r[col_r*5 +: 5] <= ROW_SENSE_LINES;                      // [RQ7] [RQ10]
            state_r <= NEXT;
          end
        end
        NEXT:
        begin
          col_r   <= next_column(col_r, column_mask_r);                      // [RQ7]
          state_r <= (next_column(col_r, column_mask_r) == 3'(keypad_pkg::COLS)) ? DONE : DRIVE;
        end
        DONE:
        begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  // results and the re-arm flag; a result read in the done cycle does not clear the new scan
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      result_r  <= 30'h00000000;
      pending_r <= 1'b0;
    end
    else if (scan_done)
    begin
      result_r  <= capture_r & key_enable(key_mask_low_r, key_mask_high_r, column_mask_r); // [RQ8] [RQ2]
      pending_r <= 1'b1;                                                    // [RQ6] [RQ9]
    end
    else if (result_read)
    begin
      pending_r <= 1'b0;                                                    // [RQ6]
    end
  end

  // column pins: all high while waiting for a press, one at a time during the scan
  always_comb
  begin
    pins_nxt.drive  = 6'h00;
    pins_nxt.enable = 6'h00;
    if ((state_r == IDLE || state_r == DEBOUNCE) && detect_en_r && !pending_r)
    begin
      pins_nxt.drive  = 6'h3f;                                              // [RQ3] [RQ1]
      pins_nxt.enable = 6'h3f;                                              // [RQ3]
    end
    else if (state_r == DRIVE || state_r == SETTLE)
    begin
      pins_nxt.drive  = 6'h01 << col_r;                                     // [RQ7]
      pins_nxt.enable = 6'h01 << col_r;                                     // [RQ7]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      COLUMN_DRIVE_LINES <= 6'h00;
      COLUMN_DRIVE_OE    <= 6'h00;
      KEY_EVENT_OUT_N    <= 1'b1;
    end
    else
    begin
      COLUMN_DRIVE_LINES <= pins_nxt.drive;
      COLUMN_DRIVE_OE    <= pins_nxt.enable;
      if (press_seen)
      begin
        KEY_EVENT_OUT_N <= 1'b0;                                            // [RQ4]
      end
      else if (scan_done || !detect_en_r)
      begin
        KEY_EVENT_OUT_N <= 1'b1;                                            // [RQ5]
      end
    end
  end

  // sticky interrupt status: a new event wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      irq_status_r <= '0;
      IRQ          <= 1'b0;
    end
    else
    begin
      irq_status_r <= (irq_status_r & ~irq_clear) |
                      {press_seen, scan_done};
      IRQ          <= |(irq_status_r & irq_enable_r);
    end
  end

endmodule
